// file: core/psb_consts.svh
/*
  constants of the synchronous burst interface: configuration field positions,
  reset values, timing figures.
  assumes: included by bare name from the package and the design modules.
*/
// Contract
// (R1) latency_type bit 14: 1 fixed latency, 0 variable latency
// (R2) latency_count bits 13..11; code 010 gives three clock latency
// (R3) wait_polarity bit 10; 0 makes wait active low
// (R4) wait_timing bit 8; 0 asserts wait during delayed cycles
// (R5) host stops link clock low during burst suspend, restarts to resume
// (R6) with oe_n low in suspend, read data keeps being driven
// (R7) host ends end-of-row with cs_n high within two or three clocks
// (R8) async write to burst read: cs_n high in variable mode
// (R9) burst read to async write: cs_n high in variable mode
// (R10) adv_n falling edge starts an asynchronous operation
// (R11) host gives refresh opportunity every 8 us of cs_n low
// (R12) burst write holds wait for latency_code cycles in both modes
// (R13) cs_n may stay low write to read within max low time
// (R14) config program: cfg_reg_sel, opcode on address, bit 19 selects register
// (R15) config program changes only bus_cfg and refresh_cfg
// (R16) host waits 150 us after power-up or deep_sleep exit
// (R17) deep_sleep lasts at least 10 us before exit
// (R18) exit deep_sleep by holding cs_n low at least 10 us
// (R19) cs_n high during burst write releases wait to high impedance
// (R20) bus_cfg bit 15 cleared selects synchronous operating mode
// (R21) adv_n low at clock edge starts burst; store_n low write, high read
`ifndef PSB_CONSTS_SVH
`define PSB_CONSTS_SVH

// -----------------------------------------------------------------
// configuration fields
// -----------------------------------------------------------------
`define PSB_MODE_BIT 15
`define PSB_LT_BIT 14
`define PSB_LC_HI 13
`define PSB_LC_LO 11
`define PSB_WP_BIT 10
`define PSB_WT_BIT 8
`define PSB_SEL_IDX 3
`define PSB_DSLP_BIT 4
`define PSB_BCR_RST 16'h1000
`define PSB_RCR_RST 16'h0000

// -----------------------------------------------------------------
// timing
// -----------------------------------------------------------------
`define PSB_CLK_NS 25
`define PSB_CEM_NS 8000
`define PSB_DPDX_NS 10000
`define PSB_PU_NS 150000

`endif

// file: core/psb_pkg.sv
/*
  types of the synchronous burst interface.
  assumes: nothing beyond the constants header.
*/
`include "psb_consts.svh"

package psb_pkg;
  // burst engine states
  typedef enum logic [3:0] {
    PSB_IDLE = 4'h1,
    PSB_LAT = 4'h2,
    PSB_XFER = 4'h4,
    PSB_ROWEND = 4'h8
  } psb_state_t;
endpackage : psb_pkg

// file: core/psb_xfer_if.sv
/*
  carrier for the configuration word passed from link clock to core clock.
  assumes: the source holds the word until the next load.
*/
interface psb_xfer_if;
  logic load;
  logic [31:0] word;
  logic [31:0] out;
  logic upd;
  modport src (output load, output word, input out, input upd);
  modport dst (input load, input word, output out, output upd);
endinterface : psb_xfer_if

// file: core/psb_xfer.sv
/*
  toggle crossing of the configuration word into the core clock domain.
  assumes: loads are spaced by more than four core clocks.
*/
`include "psb_consts.svh"

module psb_xfer import psb_pkg::*; (
  // clocks and resets
  input wire logic link_clk,
  input wire logic lrst_n,
  input wire logic core_clk,
  input wire logic rst_n,
  // carrier
  psb_xfer_if.dst x
);
  logic tgl_q, tgl_d;
  logic [31:0] hold_q, hold_d;
  logic [2:0] sync_q, sync_d;
  logic [31:0] out_q, out_d;
  logic upd_q, upd_d;

  // -----------------------------------------------------------------
  // link side
  // -----------------------------------------------------------------
  always_comb begin
    tgl_d = x.load ? ~tgl_q : tgl_q;
    hold_d = x.load ? x.word : hold_q;
  end

  always_ff @(posedge link_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      tgl_q <= 1'b0;
      hold_q <= {`PSB_BCR_RST, `PSB_RCR_RST};
    end else begin
      tgl_q <= tgl_d;
      hold_q <= hold_d;
    end
  end

  // -----------------------------------------------------------------
  // core side
  // -----------------------------------------------------------------
  always_comb begin
    sync_d = {sync_q[1:0], tgl_q};
    upd_d = sync_q[2] ^ sync_q[1];
    out_d = upd_d ? hold_q : out_q;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_q <= 3'h0;
      out_q <= {`PSB_BCR_RST, `PSB_RCR_RST};
      upd_q <= 1'b0;
    end else begin
      sync_q <= sync_d;
      out_q <= out_d;
      upd_q <= upd_d;
    end
  end

  assign x.out = out_q;
  assign x.upd = upd_q;
endmodule : psb_xfer

// file: core/psb_top.sv
/*
  synchronous burst interface of a multiplexed pseudo-static ram: burst engine,
  wait generation, configuration registers, refresh and deep sleep supervision.
  assumes: link pins are synchronous to link_clk; the host keeps its own timing.
*/
`include "psb_consts.svh"

module psb_top import psb_pkg::*; #(
  parameter int ADDR_W = 8,
  parameter int ROW_BITS = 7,
  parameter int INIT_CYC = (`PSB_PU_NS + `PSB_CLK_NS - 1) / `PSB_CLK_NS
) (
  // clocks and reset
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic link_clk,
  // link control pins
  input wire logic cs_n,
  input wire logic adv_n,
  input wire logic oe_n,
  input wire logic store_n,
  input wire logic [1:0] byte_lanes_n,
  input wire logic cfg_reg_sel,
  input wire logic [4:0] upper_addr,
  // multiplexed address and data
  input wire logic [15:0] muxed_addr_data_i,
  output logic [15:0] muxed_addr_data_o,
  output logic muxed_addr_data_oe,
  // wait pin
  output logic wait_o,
  output logic wait_oe,
  // core status
  output logic [15:0] bus_cfg,
  output logic [15:0] refresh_cfg,
  output logic async_start,
  output logic refresh_miss,
  output logic deep_sleep,
  output logic ready
);
  localparam int CEM_CYC = `PSB_CEM_NS / `PSB_CLK_NS;
  localparam int DPDX_CYC = (`PSB_DPDX_NS + `PSB_CLK_NS - 1) / `PSB_CLK_NS;

  logic [1:0] lrst_q;
  logic lrst_n;
  logic rb_m_q, rb_s_q;
  psb_state_t st_q, st_d;
  logic [4:0] cnt_q, cnt_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic rd_q, rd_d;
  logic wact_q, wact_d;
  logic wout_q, wout_d;
  logic woe_q, woe_d;
  logic doe_q, doe_d;
  logic [15:0] dout_q, dout_d;
  logic [15:0] bcr_q, bcr_d, rcr_q, rcr_d;
  logic cfg_ld;
  logic start;
  logic [3:0] lat;
  logic pend_q, pend_d, miss_q, miss_d, ast_q, ast_d;
  logic [7:0] rd_byte [2];
  psb_xfer_if xf ();

  // -----------------------------------------------------------------
  // link reset release
  // -----------------------------------------------------------------
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      lrst_q <= 2'h0;
    end else begin
      lrst_q <= {lrst_q[0], 1'b1};
    end
  end
  assign lrst_n = lrst_q[1];

  // -----------------------------------------------------------------
  // burst engine
  // -----------------------------------------------------------------
  // (R21) burst start strobe
  assign start = !cs_n && !adv_n;
  // (R2) latency from code
  assign lat = 4'({1'b0, bcr_q[`PSB_LC_HI:`PSB_LC_LO]} + 4'h1);

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    addr_d = addr_q;
    rd_d = rd_q;
    // (R20) bursts only in sync mode
    if (start && !cfg_reg_sel && !bcr_q[`PSB_MODE_BIT]) begin
      // (R21) store_n picks direction
      rd_d = store_n;
      addr_d = muxed_addr_data_i[ADDR_W-1:0];
      st_d = PSB_LAT;
      // (R1) variable read stretched by refresh
      if (store_n && !bcr_q[`PSB_LT_BIT] && rb_s_q) begin
        cnt_d = 5'({lat, 1'b0} - 5'h1);
      end else begin
        // (R12) write latency in both modes
        cnt_d = 5'({1'b0, lat} - 5'h1);
      end
    end else begin
      unique case (st_q)
        PSB_IDLE: begin
        end
        PSB_LAT: begin
          if (cnt_q == 5'h0) begin
            st_d = PSB_XFER;
          end else begin
            cnt_d = 5'(cnt_q - 5'h1);
          end
        end
        PSB_XFER: begin
          addr_d = ADDR_W'(addr_q + 1'b1);
          if (&addr_q[ROW_BITS-1:0]) begin
            st_d = PSB_ROWEND;
          end
        end
        PSB_ROWEND: begin
        end
      endcase
    end
    // (R4) wait during delay or one ahead
    wact_d = (st_d == PSB_LAT && (!bcr_q[`PSB_WT_BIT] || cnt_d != 5'h0)) ||
             st_d == PSB_ROWEND ||
             (bcr_q[`PSB_WT_BIT] && st_d == PSB_XFER && &addr_d[ROW_BITS-1:0] &&
              st_q == PSB_XFER);
    // (R3) wait level from polarity
    wout_d = bcr_q[`PSB_WP_BIT] ? wact_d : !wact_d;
    woe_d = st_d != PSB_IDLE;
    // (R6) drive while oe_n low
    doe_d = rd_d && st_d == PSB_XFER && !oe_n;
  end

  assign dout_d = {rd_byte[1], rd_byte[0]};

  // (R19) cs_n high clears engine and wait
  always_ff @(posedge link_clk or negedge lrst_n or posedge cs_n) begin
    if (!lrst_n || cs_n) begin
      st_q <= PSB_IDLE;
      cnt_q <= 5'h0;
      addr_q <= '0;
      rd_q <= 1'b0;
      wact_q <= 1'b0;
      wout_q <= 1'b0;
      woe_q <= 1'b0;
      doe_q <= 1'b0;
      dout_q <= 16'h0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      addr_q <= addr_d;
      rd_q <= rd_d;
      wact_q <= wact_d;
      wout_q <= wout_d;
      woe_q <= woe_d;
      doe_q <= doe_d;
      dout_q <= dout_d;
    end
  end

  // -----------------------------------------------------------------
  // storage, one array per byte lane
  // -----------------------------------------------------------------
  for (genvar i = 0; i < 2; i++) begin : g_lane
    logic [7:0] mem [2**ADDR_W];
    always_ff @(posedge link_clk) begin
      if (st_q == PSB_XFER && !rd_q && !cs_n && !start && !byte_lanes_n[i]) begin
        mem[addr_q] <= muxed_addr_data_i[8*i +: 8];
      end
    end
    assign rd_byte[i] = mem[addr_d];
  end

  // -----------------------------------------------------------------
  // configuration registers
  // -----------------------------------------------------------------
  always_comb begin
    bcr_d = bcr_q;
    rcr_d = rcr_q;
    cfg_ld = 1'b0;
    // (R14) opcode on address, bit 19 picks register
    if (start && cfg_reg_sel) begin
      cfg_ld = 1'b1;
      // (R15) only these two change
      if (upper_addr[`PSB_SEL_IDX]) begin
        bcr_d = muxed_addr_data_i;
      end else begin
        rcr_d = muxed_addr_data_i;
      end
    end
  end

  always_ff @(posedge link_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      bcr_q <= `PSB_BCR_RST;
      rcr_q <= `PSB_RCR_RST;
      rb_m_q <= 1'b0;
      rb_s_q <= 1'b0;
    end else begin
      bcr_q <= bcr_d;
      rcr_q <= rcr_d;
      rb_m_q <= pend_q;
      rb_s_q <= rb_m_q;
    end
  end

  assign xf.load = cfg_ld;
  assign xf.word = {bcr_d, rcr_d};

  psb_xfer u_xfer (
    .link_clk (link_clk),
    .lrst_n (lrst_n),
    .core_clk (core_clk),
    .rst_n (rst_n),
    .x (xf.dst)
  );

  // -----------------------------------------------------------------
  // core supervision
  // -----------------------------------------------------------------
  logic cs_m_q, cs_s_q, adv_m_q, adv_s_q, adv_p_q;
  logic [15:0] low_q, low_d, rtim_q, rtim_d, init_q, init_d;
  logic arm_q, arm_d, ds_q, ds_d, rdy_q, rdy_d;

  always_comb begin
    // (R10) adv_n falling edge
    ast_d = adv_p_q && !adv_s_q && !cs_s_q;
    low_d = cs_s_q ? 16'h0 : (low_q == 16'hffff ? low_q : 16'(low_q + 16'h1));
    // (R11) flag missed refresh opportunity
    miss_d = cs_s_q ? 1'b0 : (miss_q || low_q == 16'(CEM_CYC - 1));
    rtim_d = rtim_q == 16'(CEM_CYC - 1) ? 16'h0 : 16'(rtim_q + 16'h1);
    pend_d = rtim_q == 16'(CEM_CYC - 1) || (pend_q && !cs_s_q);
    arm_d = (xf.upd && xf.out[`PSB_DSLP_BIT]) || (arm_q && !cs_s_q);
    ds_d = ds_q;
    init_d = init_q == 16'(INIT_CYC) ? init_q : 16'(init_q + 16'h1);
    if (arm_q && cs_s_q) begin
      ds_d = 1'b1;
      arm_d = 1'b0;
    end
    // (R18) exit after cs_n low long enough
    if (ds_q && low_q == 16'(DPDX_CYC)) begin
      ds_d = 1'b0;
      init_d = 16'h0;
    end
    if (ds_q) begin
      init_d = 16'h0;
    end
    rdy_d = init_d == 16'(INIT_CYC) && !ds_d;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_m_q <= 1'b1;
      cs_s_q <= 1'b1;
      adv_m_q <= 1'b1;
      adv_s_q <= 1'b1;
      adv_p_q <= 1'b1;
      low_q <= 16'h0;
      rtim_q <= 16'h0;
      init_q <= 16'h0;
      pend_q <= 1'b0;
      miss_q <= 1'b0;
      ast_q <= 1'b0;
      arm_q <= 1'b0;
      ds_q <= 1'b0;
      rdy_q <= 1'b0;
    end else begin
      cs_m_q <= cs_n;
      cs_s_q <= cs_m_q;
      adv_m_q <= adv_n;
      adv_s_q <= adv_m_q;
      adv_p_q <= adv_s_q;
      low_q <= low_d;
      rtim_q <= rtim_d;
      init_q <= init_d;
      pend_q <= pend_d;
      miss_q <= miss_d;
      ast_q <= ast_d;
      arm_q <= arm_d;
      ds_q <= ds_d;
      rdy_q <= rdy_d;
    end
  end

  // -----------------------------------------------------------------
  // outputs
  // -----------------------------------------------------------------
  assign muxed_addr_data_o = dout_q;
  assign muxed_addr_data_oe = doe_q;
  assign wait_o = wout_q;
  assign wait_oe = woe_q;
  assign bus_cfg = xf.out[31:16];
  assign refresh_cfg = xf.out[15:0];
  assign async_start = ast_q;
  assign refresh_miss = miss_q;
  assign deep_sleep = ds_q;
  assign ready = rdy_q;

  // -----------------------------------------------------------------
  // assertions
  // -----------------------------------------------------------------
  logic sync_rd, sync_wr;
  assign sync_rd = start && !cfg_reg_sel && !bcr_q[`PSB_MODE_BIT] && store_n &&
                   bcr_q[`PSB_LC_HI:`PSB_LC_LO] == 3'h2 && !bcr_q[`PSB_WT_BIT];
  assign sync_wr = start && !cfg_reg_sel && !bcr_q[`PSB_MODE_BIT] && !store_n &&
                   bcr_q[`PSB_LC_HI:`PSB_LC_LO] == 3'h2;

  property p_fix_lat;
    @(posedge link_clk) disable iff (!lrst_n || cs_n)
    sync_rd && bcr_q[`PSB_LT_BIT] |=> wact_q [*3] ##1 !wact_q;
  endproperty
  a_fix_lat: assert property (p_fix_lat) else $error("fixed read latency not three"); // (R2)

  property p_var_ext;
    @(posedge link_clk) disable iff (!lrst_n || cs_n)
    sync_rd && !bcr_q[`PSB_LT_BIT] && rb_s_q |=> wact_q [*6] ##1 !wact_q;
  endproperty
  a_var_ext: assert property (p_var_ext) else $error("variable latency not stretched"); // (R1)

  property p_pol;
    @(posedge link_clk) disable iff (!lrst_n || cs_n)
    woe_q && !$past(bcr_q[`PSB_WP_BIT]) |-> wait_o == !wact_q;
  endproperty
  a_pol: assert property (p_pol) else $error("wait level wrong for polarity"); // (R3)

  property p_ahead;
    @(posedge link_clk) disable iff (!lrst_n || cs_n)
    sync_wr && bcr_q[`PSB_WT_BIT] |=> wact_q [*2] ##1 !wact_q;
  endproperty
  a_ahead: assert property (p_ahead) else $error("early wait timing wrong"); // (R4)

  property p_drive;
    @(posedge link_clk) disable iff (!lrst_n || cs_n)
    st_q == PSB_XFER && rd_q && $past(st_q) != PSB_IDLE && !$past(oe_n) |-> doe_q;
  endproperty
  a_drive: assert property (p_drive) else $error("read data not driven"); // (R6)

  property p_wr_lat;
    @(posedge link_clk) disable iff (!lrst_n || cs_n)
    sync_wr && !bcr_q[`PSB_WT_BIT] |=> wact_q [*3] ##1 (!wact_q && st_q == PSB_XFER);
  endproperty
  a_wr_lat: assert property (p_wr_lat) else $error("write wait length wrong"); // (R12)

  property p_cfg_only;
    @(posedge link_clk) disable iff (!lrst_n)
    !(start && cfg_reg_sel) |=> $stable(bcr_q) && $stable(rcr_q);
  endproperty
  a_cfg_only: assert property (p_cfg_only) else $error("config changed without program"); // (R15)

  property p_release;
    @(posedge link_clk) disable iff (!lrst_n)
    cs_n |-> !wait_oe && !muxed_addr_data_oe;
  endproperty
  a_release: assert property (p_release) else $error("wait driven with cs_n high"); // (R19)

  property p_async_mode;
    @(posedge link_clk) disable iff (!lrst_n || cs_n)
    start && !cfg_reg_sel && bcr_q[`PSB_MODE_BIT] && st_q == PSB_IDLE |=> st_q == PSB_IDLE;
  endproperty
  a_async_mode: assert property (p_async_mode) else $error("burst in async mode"); // (R20)

  property p_dir;
    @(posedge link_clk) disable iff (!lrst_n || cs_n)
    start && !cfg_reg_sel && !bcr_q[`PSB_MODE_BIT] |=> rd_q == $past(store_n);
  endproperty
  a_dir: assert property (p_dir) else $error("burst direction wrong"); // (R21)

  property p_adv_fall;
    @(posedge core_clk) disable iff (!rst_n)
    adv_p_q && !adv_s_q && !cs_s_q |=> async_start ##1 !async_start;
  endproperty
  a_adv_fall: assert property (p_adv_fall) else $error("async start pulse missing"); // (R10)

  c_read: cover property (@(posedge link_clk) disable iff (!lrst_n) doe_q);
  c_write: cover property (@(posedge link_clk) disable iff (!lrst_n) st_q == PSB_XFER && !rd_q);
  c_rowend: cover property (@(posedge link_clk) disable iff (!lrst_n) st_q == PSB_ROWEND);
  c_cfg: cover property (@(posedge link_clk) disable iff (!lrst_n) start && cfg_reg_sel);
endmodule : psb_top

// file: tb/psb_host_model.sv
/*
  host controller model: drives the link pins and a gated link clock.
  assumes: the bench calls one task at a time; the clock rests low between frames.
*/
module psb_host_model (
  // link pins
  output logic link_clk,
  output logic cs_n,
  output logic adv_n,
  output logic oe_n,
  output logic store_n,
  output logic [1:0] byte_lanes_n,
  output logic cfg_reg_sel,
  output logic [4:0] upper_addr,
  output logic [15:0] host_dq,
  // device answers
  input logic [15:0] dev_dq,
  input logic dev_oe,
  input logic wait_lvl,
  input logic wait_en
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] hd;
  logic [15:0] s_dq;
  logic [15:0] held;
  logic [15:0] held2;
  logic hoe;
  logic s_w;
  logic s_woe;
  logic s_doe;
  logic wp;
  int lat;
  int wc;
  int nrd;
  logic [15:0] rd [4];

  // released bus shows the inverse of the last value
  assign host_dq = dev_oe ? dev_dq : (hoe ? hd : ~hd);

  initial begin
    link_clk = 1'b0;
    cs_n = 1'b1;
    adv_n = 1'b1;
    oe_n = 1'b1;
    store_n = 1'b1;
    byte_lanes_n = 2'b00;
    cfg_reg_sel = 1'b0;
    upper_addr = 5'h00;
    hd = 16'h0000;
    hoe = 1'b0;
    wp = 1'b0;
    lat = 3;
  end

  function automatic logic [15:0] pat(input logic [15:0] a);
    return {a[7:0] ^ 8'h5a, a[7:0]};
  endfunction : pat

  // one link cycle: sample just before the rising edge, return on it
  task automatic cyc();
    #32 link_clk = 1'b0;
    #31 s_w = wait_lvl;
    s_woe = wait_en;
    s_doe = dev_oe;
    s_dq = dev_dq;
    #1 link_clk = 1'b1;
  endtask : cyc

  task automatic idle(input int n);
    repeat (n) cyc();
    #32 link_clk = 1'b0;
  endtask : idle

  task automatic stop();
    cs_n <= 1'b1;
    adv_n <= 1'b1;
    oe_n <= 1'b1;
    hoe <= 1'b0;
    #32 link_clk = 1'b0;
    #40;
  endtask : stop

  task automatic go(input logic cfg, input logic wr, input logic [15:0] a);
    cs_n <= 1'b0;
    adv_n <= 1'b0;
    cfg_reg_sel <= cfg;
    store_n <= !wr;
    hd <= a;
    hoe <= 1'b1;
    cyc();
    adv_n <= 1'b1;
    cfg_reg_sel <= 1'b0;
  endtask : go

  // program access, bit 3 picks register
  task automatic prog(input logic a19, input logic [15:0] op);
    upper_addr <= {1'b0, a19, 3'b000};
    go(1'b1, 1'b0, op);
    if (a19) begin
      wp = op[10];
      lat = int'(op[13:11]) + 1;
    end
    stop();
  endtask : prog

  task automatic wr(input logic [15:0] a, input int n);
    int idx;
    wc = 0;
    go(1'b0, 1'b1, a);
    for (int m = 0; m < lat + n; m++) begin
      idx = (m >= lat) ? m - lat : 0;
      hd <= pat(a + 16'(idx));
      cyc();
      if (s_woe === 1'b1 && s_w === wp) wc++;
    end
  endtask : wr

  task automatic rdb(input logic [15:0] a, input logic sus);
    wc = 0;
    nrd = 0;
    oe_n <= 1'b0;
    go(1'b0, 1'b0, a);
    hoe <= 1'b0;
    for (int g = 0; g < 20 && nrd < 4; g++) begin
      cyc();
      if (s_woe === 1'b1 && s_w === wp) wc++;
      else if (s_doe === 1'b1) begin
        rd[nrd] = s_dq;
        nrd++;
      end
      // suspend with the clock held low
      if (sus && nrd == 2) begin
        sus = 1'b0;
        #32 link_clk = 1'b0;
        #20 held = dev_dq;
        #300 held2 = dev_dq;
      end
    end
  endtask : rdb

  task automatic sel(input logic v);
    cs_n <= v;
  endtask : sel

  task automatic latch();
    cs_n <= 1'b0;
    #50 adv_n <= 1'b0;
    #100 adv_n <= 1'b1;
    #50 cs_n <= 1'b1;
  endtask : latch

  task automatic wake();
    #10000;
    cs_n <= 1'b0;
    #10500 cs_n <= 1'b1;
    #40;
  endtask : wake
endmodule : psb_host_model

// file: tb/psb_top_tb.sv
/*
  self-checking bench of the burst interface top.
  assumes: the host model owns the link pins; INIT_CYC shortened to 20.
*/
module psb_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  `define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin bad_count++; \
    $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
  logic core_clk;
  logic rst_n;
  logic link_clk;
  logic cs_n;
  logic adv_n;
  logic oe_n;
  logic store_n;
  logic [1:0] byte_lanes_n;
  logic cfg_reg_sel;
  logic [4:0] upper_addr;
  logic [15:0] dq_in;
  logic [15:0] dq_out;
  logic dq_oe;
  logic wait_lvl;
  logic wait_en;
  logic [15:0] bus_cfg;
  logic [15:0] refresh_cfg;
  logic async_start;
  logic refresh_miss;
  logic deep_sleep;
  logic ready;
  int bad_count = 0;
  int n_checks = 0;
  int n_async = 0;
  int n0;

  psb_top #(.INIT_CYC(20)) DUT (.core_clk(core_clk), .rst_n(rst_n), .link_clk(link_clk),
    .cs_n(cs_n), .adv_n(adv_n), .oe_n(oe_n), .store_n(store_n),
    .byte_lanes_n(byte_lanes_n), .cfg_reg_sel(cfg_reg_sel), .upper_addr(upper_addr),
    .muxed_addr_data_i(dq_in), .muxed_addr_data_o(dq_out), .muxed_addr_data_oe(dq_oe),
    .wait_o(wait_lvl), .wait_oe(wait_en), .bus_cfg(bus_cfg), .refresh_cfg(refresh_cfg),
    .async_start(async_start), .refresh_miss(refresh_miss), .deep_sleep(deep_sleep),
    .ready(ready));

  psb_host_model host (.link_clk(link_clk), .cs_n(cs_n), .adv_n(adv_n), .oe_n(oe_n),
    .store_n(store_n), .byte_lanes_n(byte_lanes_n), .cfg_reg_sel(cfg_reg_sel),
    .upper_addr(upper_addr), .host_dq(dq_in), .dev_dq(dq_out), .dev_oe(dq_oe),
    .wait_lvl(wait_lvl), .wait_en(wait_en));

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    if (async_start === 1'b1) n_async <= n_async + 1;
  end

  function automatic logic [15:0] expw(input logic [15:0] a);
    return {a[7:0] ^ 8'h5a, a[7:0]};
  endfunction : expw

  task automatic cw(input int n);
    repeat (n) @(posedge core_clk);
  endtask : cw

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask : done

  task automatic prg(input logic a19, input logic [15:0] op);
    host.prog(a19, op);
    cw(10);
  endtask : prg

  task automatic final_report();
    $display("checks %0d, mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : final_report

  initial begin
    #200000;
    bad_count++;
    final_report();
  end

  initial begin
    rst_n = 1'b0;
    fork
      cw(10);
      host.idle(3);
    join
    rst_n <= 1'b1;
    for (int i = 0; i < 100 && ready !== 1'b1; i++) cw(1);
    `CHK(ready, 1'b1)
    host.idle(3);
    `CHK(bus_cfg, 16'h1000)
    `CHK(refresh_cfg, 16'h0000)
    done("reset");
    host.wr(16'h0040, 2);
    `CHK(host.wc, 3)
    `CHK(wait_en, 1'b1)
    host.stop();
    `CHK(wait_en, 1'b0)
    done("write default");
    prg(1'b1, 16'h9000);
    `CHK(bus_cfg, 16'h9000)
    host.wr(16'h0050, 1);
    host.stop();
    `CHK(host.wc, 0)
    done("async mode");
    prg(1'b1, 16'h5c00);
    `CHK(bus_cfg, 16'h5c00)
    host.wr(16'h0010, 4);
    `CHK(host.wc, 4)
    host.stop();
    done("write lat4");
    prg(1'b1, 16'h5000);
    prg(1'b0, 16'h0003);
    `CHK(refresh_cfg, 16'h0003)
    `CHK(bus_cfg, 16'h5000)
    done("registers");
    host.wr(16'h007e, 2);
    `CHK(host.wc, 3)
    host.idle(1);
    `CHK(host.s_w, 1'b0)
    `CHK(host.s_woe, 1'b1)
    // select drops before the third clock after wait
    host.stop();
    done("row end");
    host.wr(16'h0030, 1);
    `CHK(host.wc, 3)
    // select stays low from write into read
    host.rdb(16'h0010, 1'b1);
    `CHK(host.wc, 3)
    for (int k = 0; k < 4; k++) `CHK(host.rd[k], expw(16'h0010 + 16'(k)))
    `CHK(host.held, expw(16'h0012))
    `CHK(host.held2, expw(16'h0012))
    host.stop();
    done("read suspend");
    n0 = n_async;
    host.latch();
    cw(10);
    `CHK(n_async - n0, 1)
    done("async start");
    prg(1'b1, 16'h1000);
    host.sel(1'b0);
    cw(300);
    `CHK(refresh_miss, 1'b0)
    cw(40);
    `CHK(refresh_miss, 1'b1)
    host.idle(2);
    host.rdb(16'h0010, 1'b0);
    `CHK(host.wc, 6)
    `CHK(host.rd[0], expw(16'h0010))
    host.stop();
    cw(10);
    `CHK(refresh_miss, 1'b0)
    done("refresh");
    prg(1'b0, 16'h0010);
    `CHK(deep_sleep, 1'b1)
    `CHK(ready, 1'b0)
    host.wake();
    cw(60);
    `CHK(deep_sleep, 1'b0)
    `CHK(ready, 1'b1)
    done("deep sleep");
    final_report();
  end
endmodule : psb_top_tb
